// File: tb/enable_and_dimming_control_tb.sv
// Purpose: self-checking bench for enable and dimming control
// Assumes: short turn-off delay of 50 cycles in simulation
// Notes:   duty measured over one full engine period of 2044 clocks
`timescale 1ns/100ps
`default_nettype none
module enable_and_dimming_control_tb;
    import en_dim_pkg::*;
    localparam int OFF_T = 50;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] cmd = 2'h0;
    logic ready = 1'b0;
    logic [LVL_W-1:0] lvl = '0;
    logic hi, lo, rdy, osc, dev_on, eng_on, gate;
    logic [LVL_W-1:0] lev;
    logic [31:0] seed = 32'h0000_9eba;
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int cnt;
    always #4 clk_sys = ~clk_sys;
    pin_host_model host (.clk_sys(clk_sys), .cmd(cmd), .ready(ready),
        .lvl(lvl), .en_pin_high(hi), .en_pin_low(lo), .supply_ready(rdy),
        .dim_osc_cap_pin(osc), .enable_dim_level(lev));
    enable_and_dimming_control #(.OFF_CYC(OFF_T)) DUT (.clk_sys(clk_sys),
        .rst_b(rst_b), .en_pin_high(hi), .en_pin_low(lo),
        .supply_ready(rdy), .dim_osc_cap_pin(osc), .enable_dim_level(lev),
        .device_on(dev_on), .engine_on(eng_on), .dim_gate_output(gate));
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %0d seen %0d", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // gate-high clocks per period; full scale keeps divider always below
    function automatic int exp_high(int l);
        int n;
        n = l * 100 - 32 * 4096;
        if (n <= 0)
            return 0;
        n = n * 511 / (24 * 4096);
        return (n > 511 ? 511 : n) * 4;
    endfunction
    // xorshift step for the repeatable random stream
    function automatic logic [31:0] xorshift(logic [31:0] s);
        logic [31:0] x;
        x = s;
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // hang guard, about 2.4 times the planned run
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            complete_run();
        end
    end
    // sample on the falling edge, drive on the rising edge
    initial begin
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        check("open pin on", dev_on, 0);
        // refused wakes: high before supply ready, mid window while off
        @(posedge clk_sys);
        cmd <= 2'h1;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        check("on before ready", dev_on, 0);
        @(posedge clk_sys);
        cmd <= 2'h2;
        ready <= 1'b1;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        check("mid window off", dev_on, 0);
        check("engine while off", eng_on, 0);
        @(posedge clk_sys);
        cmd <= 2'h1;
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        check("on", dev_on, 1);
        check("gate high", gate, 1);
        check("engine in high", eng_on, 0);
        @(posedge clk_sys);
        cmd <= 2'h0;
        repeat (OFF_T / 2) @(posedge clk_sys);
        @(negedge clk_sys);
        check("gate low", gate, 0);
        check("short low on", dev_on, 1);
        // random digital pattern, every phase shorter than the delay
        for (int j = 0; j < 6; j++) begin
            seed = xorshift(seed);
            @(posedge clk_sys);
            cmd <= (j % 2 == 0) ? 2'h1 : 2'h0;
            repeat (4 + seed % 40) @(posedge clk_sys);
            @(negedge clk_sys);
            check("pattern gate", gate, (j % 2 == 0));
            check("pattern on", dev_on, 1);
        end
        for (int i = 0; i < 8; i++) begin
            seed = xorshift(seed);
            @(posedge clk_sys);
            cmd <= 2'h2;
            lvl <= (i == 0) ? 12'h51e : (i == 1) ? 12'h8f6
                   : 12'h51f + 12'(seed % 983);
            repeat (8) @(posedge clk_sys);
            cnt = 0;
            repeat (2044) begin
                @(negedge clk_sys);
                if (gate === 1'b1)
                    cnt++;
            end
            check("engine on", eng_on, 1);
            check("duty", cnt, exp_high(int'(lvl)));
        end
        @(posedge clk_sys);
        cmd <= 2'h0;
        // off after OFF_T synced low samples, behind three pipeline edges
        repeat (OFF_T + 2) @(posedge clk_sys);
        @(negedge clk_sys);
        check("low near delay on", dev_on, 1);
        @(posedge clk_sys);
        @(negedge clk_sys);
        check("long low on", dev_on, 0);
        check("long low gate", gate, 0);
        check("long low engine", eng_on, 0);
        // wake again, then a reset in mid-run and a fresh wake
        @(posedge clk_sys);
        cmd <= 2'h1;
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        check("rewake on", dev_on, 1);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        check("reset on", dev_on, 0);
        check("reset gate", gate, 0);
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        check("early after reset", dev_on, 0);
        @(posedge clk_sys);
        @(negedge clk_sys);
        check("wake after reset", dev_on, 1);
        complete_run();
    end
endmodule
`default_nettype wire

// File: tb/pin_host_model.sv
// Purpose: host side of the enable/dim pin, seen through the comparators
// Assumes: bench picks the pin state with cmd; open pin reads low
// Notes:   cap oscillator toggles every two clocks, period four clocks
`timescale 1ns/100ps
`default_nettype none
module pin_host_model
    import en_dim_pkg::*;
(
    // clock and bench command
    input  wire logic             clk_sys,
    input  wire logic [1:0]       cmd,
    input  wire logic             ready,
    input  wire logic [LVL_W-1:0] lvl,
    // comparator, supply and converter outputs
    output var  logic             en_pin_high,
    output var  logic             en_pin_low,
    output var  logic             supply_ready,
    output var  logic             dim_osc_cap_pin,
    output var  logic [LVL_W-1:0] enable_dim_level
);
    logic ph;
    // pull-down wins while nothing drives the pin
    initial begin
        {ph, en_pin_high, supply_ready, dim_osc_cap_pin} = 4'h0;
        en_pin_low = 1'b1;
        enable_dim_level = '0;
    end
    // cmd 0 low, 1 high, 2 mid window
    always @(posedge clk_sys) begin
        ph <= ~ph;
        if (ph)
            dim_osc_cap_pin <= ~dim_osc_cap_pin;
        en_pin_high <= (cmd == 2'h1);
        en_pin_low <= (cmd == 2'h0);
        supply_ready <= ready;
        enable_dim_level <= lvl;
    end
endmodule
`default_nettype wire

// File: verilog/en_dim_pkg.sv
// Purpose: shared constants and carrier types for the enable/dimming block
// Assumes: clk_sys at 125 MHz; analog pin already digitised off-chip
// Notes:   level code is the pin voltage as a fraction of internal supply
`default_nettype none
package en_dim_pkg;
    // clock
    localparam int unsigned CLK_PERIOD_NS  = 8;
    // enable turn-off delay, typical figure
    localparam int unsigned OFF_DELAY_NS   = 10_000_000;
    localparam int unsigned OFF_DELAY_CYC  = OFF_DELAY_NS / CLK_PERIOD_NS;
    // level converter width; full scale equals the internal supply
    localparam int unsigned LVL_W          = 12;
    // engine window edges and span, in percent of internal supply
    localparam int unsigned WIN_LO_PCT     = 32;
    localparam int unsigned WIN_SPAN_PCT   = 24;
    localparam int unsigned PCT_SCALE      = 100;
    // oscillator cycles per engine period
    localparam int unsigned DIV_CYCLES     = 511;
    localparam int unsigned DIV_W          = 9;
    localparam int unsigned DUTY_W         = 10;

    // pin-side status, after synchronisation
    typedef struct packed {
        logic             pin_high;     // above valid high level
        logic             pin_low;      // below valid low level
        logic             supply_ready; // internal_supply past rising level
        logic             osc_cmp;      // cap oscillator charge phase
        logic [LVL_W-1:0] level;        // pin voltage / internal_supply
    } pin_status_t;

    typedef enum logic {
        ST_OFF,
        ST_RUN
    } run_state_t;
endpackage
`default_nettype wire

// File: verilog/enable_and_dimming_control.sv
// Purpose: enable detection, digital and embedded dimming of a boost driver
// Assumes: comparators, level converter and cap oscillator sit outside
// Notes:   all pin-side inputs are asynchronous and pass two flip-flops
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - long valid low powers device off
// - valid high powers on once the supply is up, accepts digital dimming
// - gate follows input: high on, low off
// - short lows are dimming, not shutdown
// - mid window runs engine driving gate
// - duty from level: (v-0.32)/0.24 of the period
// - period is 511 cap oscillator cycles
// - engine waveform gates drivers like digital
// - open pin pulled low stays off
module enable_and_dimming_control
    import en_dim_pkg::*;
#(
    parameter int unsigned OFF_CYC = OFF_DELAY_CYC
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    // pin-side comparators and converter, asynchronous
    input  wire logic             en_pin_high,
    input  wire logic             en_pin_low,
    input  wire logic             supply_ready,
    input  wire logic             dim_osc_cap_pin,
    input  wire logic [LVL_W-1:0] enable_dim_level,
    // to power stage
    output var  logic             device_on,
    output var  logic             engine_on,
    output var  logic             dim_gate_output
);
    localparam int unsigned CNT_W = $clog2(OFF_CYC + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(OFF_CYC - 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_CYCLES - 1);
    localparam logic [DUTY_W-1:0] DUTY_FULL = DUTY_W'(DIV_CYCLES);
    localparam int unsigned FS = 1 << LVL_W;
    localparam int unsigned LO_NUM = WIN_LO_PCT * FS;
    localparam int unsigned HI_NUM = (WIN_LO_PCT + WIN_SPAN_PCT) * FS;
    localparam int unsigned SPAN_NUM = WIN_SPAN_PCT * FS;

    pin_status_t  meta;
    pin_status_t  sync;
    logic         osc_prev;
    run_state_t   state;
    run_state_t   next_state;
    logic [CNT_W-1:0]  low_cnt;
    logic [DIV_W-1:0]  div_cnt;
    logic [LVL_W-1:0]  level_prev;
    logic [LVL_W-1:0]  level_hold;

    // two-stage synchroniser; only the second stage feeds logic
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            meta <= '0;
            sync <= '0;
        end else begin
            meta <= '{en_pin_high, en_pin_low, supply_ready,
                      dim_osc_cap_pin, enable_dim_level};
            sync <= meta;
        end
    end

    // pin classification
    wire in_high   = sync.pin_high;
    wire in_low    = sync.pin_low;
    wire in_window = !sync.pin_high && !sync.pin_low;
    wire osc_rise  = sync.osc_cmp && !osc_prev;

    // level word crosses bit by bit, so a change can land half-taken;
    // accept it only once two samples in a row agree, costing two clocks
    wire level_steady = (sync.level == level_prev);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            level_prev <= '0;
            level_hold <= '0;
        end else begin
            level_prev <= sync.level;
            if (level_steady) begin
                level_hold <= level_prev;
            end
        end
    end

    a_level_filter: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        !level_steady |=> level_hold == $past(level_hold))
        else $error("unsettled level word reached duty");

    // duty from the filtered level, clamped at the window edges
    wire [31:0] lvl_num = 32'(level_hold) * PCT_SCALE;
    wire        at_lo   = lvl_num <= LO_NUM;
    wire        at_hi   = lvl_num >= HI_NUM;
    wire [31:0] duty_raw = ((lvl_num - LO_NUM) * DIV_CYCLES)
                           / SPAN_NUM;
    wire [DUTY_W-1:0] duty = at_lo ? '0 :
                             at_hi ? DUTY_FULL :
                             duty_raw[DUTY_W-1:0];
    wire        engine_gate = {1'b0, div_cnt} < duty;

    // shutdown after a low that outlasts the turn-off delay
    wire low_expired = in_low && (low_cnt == CNT_LAST);

    // off: wake only on valid high once the supply is up
    always_comb begin
        next_state = state;
        unique case (state)
            ST_OFF: if (in_high && sync.supply_ready)
                        next_state = ST_RUN;
            ST_RUN: if (low_expired)
                        next_state = ST_OFF;
        endcase
    end

    // gate select: digital pattern or engine waveform
    wire next_gate = (next_state == ST_RUN) && (state == ST_RUN) &&
                     (in_high || (in_window && engine_gate));

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // low-phase timer, cleared by any non-low sample
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            low_cnt <= '0;
        end else if (state == ST_RUN && in_low && !low_expired) begin
            low_cnt <= low_cnt + 1'b1;
        end else begin
            low_cnt <= '0;
        end
    end

    // engine divider, one step per oscillator cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            osc_prev <= 1'b0;
            div_cnt  <= '0;
        end else begin
            osc_prev <= sync.osc_cmp;
            if (osc_rise) begin
                div_cnt <= (div_cnt == DIV_LAST) ? '0
                                                 : div_cnt + 1'b1;
            end
        end
    end

    // registered outputs
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            device_on       <= 1'b0;
            engine_on       <= 1'b0;
            dim_gate_output <= 1'b0;
        end else begin
            device_on       <= next_state == ST_RUN;
            engine_on       <= (next_state == ST_RUN) && in_window;
            dim_gate_output <= next_gate;
        end
    end

    a_off_stays_low: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (state == ST_OFF && !in_high) |=> !device_on && !dim_gate_output)
        else $error("device woke without valid high");
    a_wake_needs_ready: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        $rose(device_on) |-> $past(in_high) && $past(sync.supply_ready))
        else $error("woke without high and supply ready");
    a_gate_follows_high: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (state == ST_RUN && in_high) |=> dim_gate_output)
        else $error("gate off during high input");
    a_gate_low_off: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (state == ST_RUN && in_low) |=> !dim_gate_output)
        else $error("gate on during low input");
    a_short_low_runs: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (state == ST_RUN && in_low && low_cnt < CNT_LAST) |=> device_on)
        else $error("shutdown before delay elapsed");
    a_long_low_off: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (state == ST_RUN && low_expired)
        |=> !device_on && !dim_gate_output && state == ST_OFF)
        else $error("no shutdown after delay");
    a_engine_gate_dc: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (state == ST_RUN && in_window && next_state == ST_RUN)
        |=> engine_on && dim_gate_output == $past(engine_gate))
        else $error("engine gate mismatch");
    a_duty_clamp: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (at_lo |-> duty == '0) and (at_hi |-> duty == DUTY_FULL))
        else $error("duty not clamped");
    a_div_wrap: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (osc_rise && div_cnt == DIV_LAST) |=> div_cnt == '0)
        else $error("divider did not wrap at 511");
    a_duty_mid: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (!at_lo && !at_hi) |-> duty < DUTY_FULL)
        else $error("mid-window duty out of range");

    // clamp seen at the gate: zero duty never pulses, full never drops
    a_clamp_gate_lo: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (state == ST_RUN && next_state == ST_RUN && in_window && at_lo)
        |=> !dim_gate_output)
        else $error("gate pulsed at zero duty");
    a_clamp_gate_hi: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (state == ST_RUN && next_state == ST_RUN && in_window && at_hi)
        |=> dim_gate_output)
        else $error("gate dropped at full duty");
    a_engine_off_pins: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (in_high || in_low) |=> !engine_on)
        else $error("engine on outside the window");
    a_low_cnt_bound: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        low_cnt <= CNT_LAST)
        else $error("low timer ran past the delay");
endmodule

`default_nettype wire
